//--- rtl/bit_plane_and_scalar_logic.sv
`timescale 1ns/100ps
// Notes on behaviour
// - or-with-literal ORs optionally inverted register, writes back
// - nor-with-literal stores NOR of register and literal
// - literal zero-extended to 32 bits
// - inverted-literal variants complement the extended literal
// - register OR with optional inversion of each
// - first field is source and destination; second is source
// - pause halts with number 1..262143 until restart
// - result loads activity or its complement
// - load result from activity then clear carry
// - broadcast one register bit, or complement, to result
// - broadcast uses bit index, ignores plane address
// - result loads carry or its complement
// - result loads carry, then carry cleared
// - result is XNOR of store plane and bit
// - equivalence uses plane address and bit index
// - out-of-block store address in an equivalence raises run-time error
// - clear result plane
// - clear result and activity planes
// - clear result and carry planes
// - result is carry XOR activity or its complement
// - result becomes result XOR carry
module bit_plane_and_scalar_logic #(
  parameter int PLANE_BITS = 64,
  parameter int NUM_REGS = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  input wire bit_plane_pkg::opcode_t opcode,
  input wire logic [bit_plane_pkg::REG_FIELD_WIDTH-1:0] dest_reg_field,
  input wire logic [bit_plane_pkg::REG_FIELD_WIDTH-1:0] second_reg_field,
  input wire logic inv_first,
  input wire logic inv_second,
  input wire logic [bit_plane_pkg::LITERAL_WIDTH-1:0] literal,
  input wire logic [bit_plane_pkg::SCALAR_WIDTH-1:0] scalar_load_data,
  input wire logic use_edge_reg,
  input wire logic [bit_plane_pkg::SCALAR_WIDTH-1:0] edge_reg_value,
  input wire logic [bit_plane_pkg::BIT_INDEX_WIDTH-1:0] eff_bit_index,
  input wire logic [bit_plane_pkg::PLANE_ADDR_WIDTH-1:0] eff_plane_addr,
  input wire logic [bit_plane_pkg::PLANE_ADDR_WIDTH-1:0] block_base,
  input wire logic [bit_plane_pkg::PLANE_ADDR_WIDTH-1:0] block_limit,
  input wire logic [PLANE_BITS-1:0] store_plane_data,
  input wire logic [bit_plane_pkg::PAUSE_WIDTH-1:0] pause_number,
  input wire logic restart,
  input wire logic error_clear,
  output logic [PLANE_BITS-1:0] result_plane_reg,
  output logic [PLANE_BITS-1:0] activity_plane_reg,
  output logic [PLANE_BITS-1:0] carry_plane_reg,
  output logic [bit_plane_pkg::SCALAR_WIDTH-1:0] scalar_result_reg,
  output logic [bit_plane_pkg::REG_FIELD_WIDTH-1:0] scalar_result_idx_reg,
  output logic scalar_result_valid_reg,
  output logic paused_reg,
  output logic [bit_plane_pkg::PAUSE_WIDTH-1:0] pause_code_reg,
  output logic runtime_error_reg,
  output logic done_reg
);
  localparam int SW = bit_plane_pkg::SCALAR_WIDTH;

  bit_plane_pkg::exec_state_t state_reg;
  bit_plane_pkg::exec_state_t state_next;
  logic [SW-1:0] regs_reg [NUM_REGS];
  logic accept;
  logic [SW-1:0] opnd_a;
  logic [SW-1:0] opnd_b;
  logic [SW-1:0] lit_ext;
  logic [SW-1:0] scalar_next;
  logic scalar_write;
  logic [SW-1:0] bit_source;
  logic sel_bit;
  logic addr_bad;
  logic pause_ok;
  logic [PLANE_BITS-1:0] result_next;
  logic [PLANE_BITS-1:0] activity_next;
  logic [PLANE_BITS-1:0] carry_next;

  assign accept = instr_valid && (state_reg == bit_plane_pkg::ST_RUN);
  // first field names both the first source and the destination
  assign opnd_a = inv_first ? ~regs_reg[dest_reg_field] : regs_reg[dest_reg_field];
  assign opnd_b = inv_second ? ~regs_reg[second_reg_field] : regs_reg[second_reg_field];
  assign lit_ext = {bit_plane_pkg::LITERAL_UPPER_ZERO, literal};
  assign bit_source = use_edge_reg ? edge_reg_value : regs_reg[dest_reg_field];
  // only the bit index picks the bit; plane address plays no part here
  assign sel_bit = bit_source[eff_bit_index];
  assign addr_bad = (eff_plane_addr < block_base) || (eff_plane_addr > block_limit);
  assign pause_ok = (pause_number >= bit_plane_pkg::PAUSE_MIN) && (pause_number <= bit_plane_pkg::PAUSE_MAX);

  always_comb
  begin
    scalar_next = opnd_a;
    scalar_write = 1'b0;
    case (opcode)
      bit_plane_pkg::OP_OR_REG:
      begin
        scalar_next = opnd_a | opnd_b;
        scalar_write = 1'b1;
      end
      bit_plane_pkg::OP_OR_WITH_LITERAL:
      begin
        scalar_next = opnd_a | lit_ext;
        scalar_write = 1'b1;
      end
      bit_plane_pkg::OP_OR_WITH_INV_LITERAL:
      begin
        scalar_next = opnd_a | ~lit_ext;
        scalar_write = 1'b1;
      end
      bit_plane_pkg::OP_NOR_WITH_LITERAL:
      begin
        scalar_next = ~(opnd_a | lit_ext);
        scalar_write = 1'b1;
      end
      bit_plane_pkg::OP_NOR_WITH_INV_LITERAL:
      begin
        scalar_next = ~(opnd_a | ~lit_ext);
        scalar_write = 1'b1;
      end
      bit_plane_pkg::OP_LOAD_SCALAR:
      begin
        scalar_next = scalar_load_data;
        scalar_write = 1'b1;
      end
      default: scalar_write = 1'b0;
    endcase
  end

  // each plane element takes its new value from its own operand bits; broadcast uses only the one selected bit sel_bit, equivalence uses it too
  always_comb
  begin
    result_next = result_plane_reg;
    activity_next = activity_plane_reg;
    carry_next = carry_plane_reg;
    case (opcode)
      bit_plane_pkg::OP_COPY_ACTIVITY_TO_RESULT: result_next = activity_plane_reg;
      bit_plane_pkg::OP_COPY_INV_ACTIVITY_TO_RESULT: result_next = ~activity_plane_reg;
      bit_plane_pkg::OP_COPY_ACTIVITY_CLEAR_CARRY:
      begin
        result_next = activity_plane_reg;
        carry_next = '0;
      end
      bit_plane_pkg::OP_COPY_INV_ACTIVITY_CLEAR_CARRY:
      begin
        result_next = ~activity_plane_reg;
        carry_next = '0;
      end
      bit_plane_pkg::OP_BROADCAST_REG_BIT: result_next = {PLANE_BITS{sel_bit}};
      bit_plane_pkg::OP_BROADCAST_INV_REG_BIT: result_next = {PLANE_BITS{~sel_bit}};
      bit_plane_pkg::OP_COPY_CARRY_TO_RESULT: result_next = carry_plane_reg;
      bit_plane_pkg::OP_COPY_INV_CARRY_TO_RESULT: result_next = ~carry_plane_reg;
      bit_plane_pkg::OP_COPY_CARRY_THEN_CLEAR:
      begin
        result_next = carry_plane_reg;
        carry_next = '0;
      end
      bit_plane_pkg::OP_EQUIV_BIT_WITH_STORE:
      begin
        if (!addr_bad)
        begin
          result_next = ~(store_plane_data ^ {PLANE_BITS{sel_bit}});
        end
      end
      bit_plane_pkg::OP_EQUIV_BIT_WITH_INV_STORE:
      begin
        if (!addr_bad)
        begin
          result_next = ~(~store_plane_data ^ {PLANE_BITS{sel_bit}});
        end
      end
      bit_plane_pkg::OP_CLEAR_RESULT_PLANE: result_next = '0;
      bit_plane_pkg::OP_CLEAR_RESULT_AND_ACTIVITY:
      begin
        result_next = '0;
        activity_next = '0;
      end
      bit_plane_pkg::OP_CLEAR_RESULT_AND_CARRY:
      begin
        result_next = '0;
        carry_next = '0;
      end
      bit_plane_pkg::OP_SUM_CARRY_ACTIVITY: result_next = carry_plane_reg ^ activity_plane_reg;
      bit_plane_pkg::OP_SUM_CARRY_INV_ACTIVITY: result_next = carry_plane_reg ^ ~activity_plane_reg;
      bit_plane_pkg::OP_SUM_CARRY_INTO_RESULT: result_next = result_plane_reg ^ carry_plane_reg;
      bit_plane_pkg::OP_LOAD_ACTIVITY: activity_next = store_plane_data;
      bit_plane_pkg::OP_LOAD_CARRY: carry_next = store_plane_data;
      default: result_next = result_plane_reg;
    endcase
  end

  // planes move together in a single step
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      result_plane_reg <= '0;
      activity_plane_reg <= '0;
      carry_plane_reg <= '0;
    end
    else if (accept)
    begin
      result_plane_reg <= result_next;
      activity_plane_reg <= activity_next;
      carry_plane_reg <= carry_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_reg[i] <= bit_plane_pkg::SCALAR_RESET;
    end
    else if (accept && scalar_write)
    begin
      regs_reg[dest_reg_field] <= scalar_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scalar_result_reg <= bit_plane_pkg::SCALAR_RESET;
      scalar_result_idx_reg <= '0;
      scalar_result_valid_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      scalar_result_valid_reg <= accept && scalar_write;
      done_reg <= accept;
      if (accept && scalar_write)
      begin
        scalar_result_reg <= scalar_next;
        scalar_result_idx_reg <= dest_reg_field;
      end
    end
  end

  // pause holds off further instructions until restart
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      bit_plane_pkg::ST_RUN:
        if (accept && opcode == bit_plane_pkg::OP_PAUSE && pause_ok)
          state_next = bit_plane_pkg::ST_PAUSED;
      bit_plane_pkg::ST_PAUSED:
        if (restart)
          state_next = bit_plane_pkg::ST_RUN;
      default: state_next = bit_plane_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= bit_plane_pkg::ST_RUN;
      paused_reg <= 1'b0;
      pause_code_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      paused_reg <= (state_next == bit_plane_pkg::ST_PAUSED);
      if (accept && opcode == bit_plane_pkg::OP_PAUSE && pause_ok)
        pause_code_reg <= pause_number;
    end
  end

  // sticky error; a new error wins over a clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      runtime_error_reg <= 1'b0;
    end
    else if (accept && ((addr_bad && (opcode == bit_plane_pkg::OP_EQUIV_BIT_WITH_STORE
             || opcode == bit_plane_pkg::OP_EQUIV_BIT_WITH_INV_STORE))
             || (opcode == bit_plane_pkg::OP_PAUSE && !pause_ok)))
    begin
      runtime_error_reg <= 1'b1;
    end
    else if (error_clear)
    begin
      runtime_error_reg <= 1'b0;
    end
  end

  a_or_literal: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opcode == bit_plane_pkg::OP_OR_WITH_LITERAL
    |=> scalar_result_valid_reg && scalar_result_reg == ($past(opnd_a) | {16'h0000, $past(literal)}))
    else $error("or with literal result wrong");
  a_nor_inv_lit: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opcode == bit_plane_pkg::OP_NOR_WITH_INV_LITERAL
    |=> scalar_result_reg[31:16] == 16'h0000 && scalar_result_reg[15:0] == ($past(~opnd_a[15:0]) & $past(literal)))
    else $error("nor with inverted literal result wrong");
  a_copy_act_cc: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opcode == bit_plane_pkg::OP_COPY_INV_ACTIVITY_CLEAR_CARRY
    |=> result_plane_reg == ~$past(activity_plane_reg) && carry_plane_reg == '0)
    else $error("copy inverted activity and clear carry wrong");
  a_broadcast_bit: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opcode == bit_plane_pkg::OP_BROADCAST_REG_BIT
    |=> (result_plane_reg == '0 || result_plane_reg == '1) && result_plane_reg[0] == $past(sel_bit))
    else $error("broadcast bit not uniform");
  a_carry_clear: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opcode == bit_plane_pkg::OP_COPY_CARRY_THEN_CLEAR
    |=> result_plane_reg == $past(carry_plane_reg) && carry_plane_reg == '0)
    else $error("copy carry then clear wrong");
  a_equiv_error: assert property (@(posedge clk_sys) disable iff (rst)
    accept && addr_bad && opcode == bit_plane_pkg::OP_EQUIV_BIT_WITH_STORE
    |=> runtime_error_reg && $stable(result_plane_reg))
    else $error("bad store address not flagged");
  a_clear_both: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opcode == bit_plane_pkg::OP_CLEAR_RESULT_AND_ACTIVITY
    |=> result_plane_reg == '0 && activity_plane_reg == '0 && carry_plane_reg == $past(carry_plane_reg))
    else $error("clear result and activity wrong");
  a_sum_result: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opcode == bit_plane_pkg::OP_SUM_CARRY_INTO_RESULT
    |=> result_plane_reg == ($past(result_plane_reg) ^ $past(carry_plane_reg)))
    else $error("sum carry into result wrong");
  a_nop_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opcode == bit_plane_pkg::OP_NOP && !error_clear
    |=> $stable(result_plane_reg) && $stable(activity_plane_reg) && $stable(carry_plane_reg)
        && !scalar_result_valid_reg && runtime_error_reg == $past(runtime_error_reg))
    else $error("no-operation changed state");
  a_pause_hold: assert property (@(posedge clk_sys) disable iff (rst)
    accept && opcode == bit_plane_pkg::OP_PAUSE && pause_ok
    |=> paused_reg && pause_code_reg == $past(pause_number))
    else $error("pause not entered");
endmodule

//--- rtl/bit_plane_pkg.sv
package bit_plane_pkg;
  localparam int SCALAR_WIDTH = 32;
  localparam int LITERAL_WIDTH = 16;
  localparam int REG_FIELD_WIDTH = 4;
  localparam int BIT_INDEX_WIDTH = 5;
  localparam int PLANE_ADDR_WIDTH = 16;
  localparam int PAUSE_WIDTH = 18;
  localparam logic [PAUSE_WIDTH-1:0] PAUSE_MIN = 18'h00001;
  localparam logic [PAUSE_WIDTH-1:0] PAUSE_MAX = 18'h3FFFF;
  localparam logic [SCALAR_WIDTH-1:0] SCALAR_RESET = 32'h00000000;
  localparam logic [LITERAL_WIDTH-1:0] LITERAL_UPPER_ZERO = 16'h0000;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_OR_REG = 5'h01,
    OP_OR_WITH_LITERAL = 5'h02,
    OP_OR_WITH_INV_LITERAL = 5'h03,
    OP_NOR_WITH_LITERAL = 5'h04,
    OP_NOR_WITH_INV_LITERAL = 5'h05,
    OP_PAUSE = 5'h06,
    OP_COPY_ACTIVITY_TO_RESULT = 5'h07,
    OP_COPY_INV_ACTIVITY_TO_RESULT = 5'h08,
    OP_COPY_ACTIVITY_CLEAR_CARRY = 5'h09,
    OP_COPY_INV_ACTIVITY_CLEAR_CARRY = 5'h0A,
    OP_BROADCAST_REG_BIT = 5'h0B,
    OP_BROADCAST_INV_REG_BIT = 5'h0C,
    OP_COPY_CARRY_TO_RESULT = 5'h0D,
    OP_COPY_INV_CARRY_TO_RESULT = 5'h0E,
    OP_COPY_CARRY_THEN_CLEAR = 5'h0F,
    OP_EQUIV_BIT_WITH_STORE = 5'h10,
    OP_EQUIV_BIT_WITH_INV_STORE = 5'h11,
    OP_CLEAR_RESULT_PLANE = 5'h12,
    OP_CLEAR_RESULT_AND_ACTIVITY = 5'h13,
    OP_CLEAR_RESULT_AND_CARRY = 5'h14,
    OP_SUM_CARRY_ACTIVITY = 5'h15,
    OP_SUM_CARRY_INV_ACTIVITY = 5'h16,
    OP_SUM_CARRY_INTO_RESULT = 5'h17,
    OP_LOAD_ACTIVITY = 5'h18,
    OP_LOAD_CARRY = 5'h19,
    OP_LOAD_SCALAR = 5'h1A
  } opcode_t;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_PAUSED = 1'b1
  } exec_state_t;
endpackage

//--- tb/pause_service_model.sv
`timescale 1ns/100ps
module pause_service_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic paused_reg,
  input wire logic [7:0] wait_cycles,
  output logic restart = 1'b0
);
  int cnt = 0;
  // acts on a pause after a chosen delay, then restarts the program
  always @(posedge clk_sys)
  begin
    if (rst || !paused_reg)
    begin
      cnt <= 0;
      restart <= 1'b0;
    end
    else if (cnt >= wait_cycles)
      restart <= 1'b1;
    else
      cnt <= cnt + 1;
  end
endmodule

//--- tb/bit_plane_and_scalar_logic_tb_top.sv
`timescale 1ns/100ps
module bit_plane_and_scalar_logic_tb_top;
  typedef struct {logic [63:0] q, a, c; logic [31:0] s; logic [3:0] i; logic sv, e;} exp_t;
  logic clk_sys = 1'b0, rst = 1'b1, instr_valid = 1'b0, inv_first = 1'b0, inv_second = 1'b0;
  bit_plane_pkg::opcode_t opcode = bit_plane_pkg::OP_NOP;
  logic [3:0] dest_reg_field = 4'h0, second_reg_field = 4'h0, scalar_result_idx_reg;
  logic [15:0] literal = 16'h0000, eff_plane_addr = 16'h0000, block_base = 16'h0100, block_limit = 16'h01FF;
  logic [31:0] scalar_load_data = 32'h0, edge_reg_value = 32'h0, scalar_result_reg;
  logic [4:0] eff_bit_index = 5'h00;
  logic [63:0] store_plane_data = 64'h0, result_plane_reg, activity_plane_reg, carry_plane_reg;
  logic [17:0] pause_number = 18'h00001, pause_code_reg;
  logic use_edge_reg = 1'b0, error_clear = 1'b0, restart, paused_reg, runtime_error_reg;
  logic done_reg, scalar_result_valid_reg;
  logic [7:0] wait_cycles = 8'h00;
  logic [31:0] regs [16];
  exp_t m, x;
  exp_t notes[$];
  int n_mismatch = 0, num_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  bit_plane_and_scalar_logic #(.PLANE_BITS(64), .NUM_REGS(16)) dut_u (.clk_sys, .rst, .instr_valid, .opcode,
    .dest_reg_field, .second_reg_field, .inv_first, .inv_second, .literal, .scalar_load_data, .use_edge_reg,
    .edge_reg_value, .eff_bit_index, .eff_plane_addr, .block_base, .block_limit, .store_plane_data,
    .pause_number, .restart, .error_clear, .result_plane_reg, .activity_plane_reg, .carry_plane_reg,
    .scalar_result_reg, .scalar_result_idx_reg, .scalar_result_valid_reg, .paused_reg, .pause_code_reg,
    .runtime_error_reg, .done_reg);

  pause_service_model partner_u (.clk_sys, .rst, .paused_reg, .wait_cycles, .restart);

  task chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    num_checks++;
    if (ex !== got)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // oldest note is compared whenever the design reports a finished instruction
  always @(negedge clk_sys)
  begin
    if (!rst && done_reg === 1'b1)
    begin
      if (notes.size() == 0)
        chk("spurious done", 64'h0, 64'h1);
      else
      begin
        x = notes.pop_front();
        chk("result plane", x.q, result_plane_reg);
        chk("activity plane", x.a, activity_plane_reg);
        chk("carry plane", x.c, carry_plane_reg);
        chk("error flag", x.e, runtime_error_reg);
        chk("scalar valid", x.sv, scalar_result_valid_reg);
        if (x.sv)
        begin
          chk("scalar value", x.s, scalar_result_reg);
          chk("scalar index", x.i, scalar_result_idx_reg);
        end
      end
    end
  end

  task go(input bit_plane_pkg::opcode_t o);
    logic [31:0] p, r, l;
    logic b, ok;
    @(negedge clk_sys);
    instr_valid = 1'b1;
    opcode = o;
    dest_reg_field = 4'($urandom);
    second_reg_field = 4'($urandom);
    inv_first = 1'($urandom);
    inv_second = 1'($urandom);
    literal = 16'($urandom);
    scalar_load_data = $urandom;
    use_edge_reg = 1'($urandom);
    edge_reg_value = $urandom;
    eff_bit_index = 5'($urandom);
    eff_plane_addr = 16'h00FE + 16'($urandom % 260);
    store_plane_data = {$urandom, $urandom};
    p = inv_first ? ~regs[dest_reg_field] : regs[dest_reg_field];
    r = inv_second ? ~regs[second_reg_field] : regs[second_reg_field];
    l = {16'h0000, literal};
    b = use_edge_reg ? edge_reg_value[eff_bit_index] : regs[dest_reg_field][eff_bit_index];
    ok = eff_plane_addr >= block_base && eff_plane_addr <= block_limit;
    m.sv = 1'b1;
    m.i = dest_reg_field;
    case (o)
      bit_plane_pkg::OP_OR_REG: m.s = p | r;
      bit_plane_pkg::OP_OR_WITH_LITERAL: m.s = p | l;
      bit_plane_pkg::OP_OR_WITH_INV_LITERAL: m.s = p | ~l;
      bit_plane_pkg::OP_NOR_WITH_LITERAL: m.s = ~(p | l);
      bit_plane_pkg::OP_NOR_WITH_INV_LITERAL: m.s = ~(p | ~l);
      bit_plane_pkg::OP_LOAD_SCALAR: m.s = scalar_load_data;
      default: m.sv = 1'b0;
    endcase
    case (o)
      bit_plane_pkg::OP_COPY_ACTIVITY_TO_RESULT: m.q = m.a;
      bit_plane_pkg::OP_COPY_INV_ACTIVITY_TO_RESULT: m.q = ~m.a;
      bit_plane_pkg::OP_COPY_ACTIVITY_CLEAR_CARRY: {m.q, m.c} = {m.a, 64'h0};
      bit_plane_pkg::OP_COPY_INV_ACTIVITY_CLEAR_CARRY: {m.q, m.c} = {~m.a, 64'h0};
      bit_plane_pkg::OP_BROADCAST_REG_BIT: m.q = {64{b}};
      bit_plane_pkg::OP_BROADCAST_INV_REG_BIT: m.q = {64{~b}};
      bit_plane_pkg::OP_COPY_CARRY_TO_RESULT: m.q = m.c;
      bit_plane_pkg::OP_COPY_INV_CARRY_TO_RESULT: m.q = ~m.c;
      bit_plane_pkg::OP_COPY_CARRY_THEN_CLEAR: {m.q, m.c} = {m.c, 64'h0};
      bit_plane_pkg::OP_EQUIV_BIT_WITH_STORE: {m.q, m.e} = ok ? {~(store_plane_data ^ {64{b}}), m.e} : {m.q, 1'b1};
      bit_plane_pkg::OP_EQUIV_BIT_WITH_INV_STORE: {m.q, m.e} = ok ? {store_plane_data ^ {64{b}}, m.e} : {m.q, 1'b1};
      bit_plane_pkg::OP_CLEAR_RESULT_PLANE: m.q = 64'h0;
      bit_plane_pkg::OP_CLEAR_RESULT_AND_ACTIVITY: {m.q, m.a} = 128'h0;
      bit_plane_pkg::OP_CLEAR_RESULT_AND_CARRY: {m.q, m.c} = 128'h0;
      bit_plane_pkg::OP_SUM_CARRY_ACTIVITY: m.q = m.c ^ m.a;
      bit_plane_pkg::OP_SUM_CARRY_INV_ACTIVITY: m.q = m.c ^ ~m.a;
      bit_plane_pkg::OP_SUM_CARRY_INTO_RESULT: m.q = m.q ^ m.c;
      bit_plane_pkg::OP_LOAD_ACTIVITY: m.a = store_plane_data;
      bit_plane_pkg::OP_LOAD_CARRY: m.c = store_plane_data;
      bit_plane_pkg::OP_PAUSE: m.e = m.e | (pause_number < bit_plane_pkg::PAUSE_MIN);
      default: ;
    endcase
    if (m.sv)
      regs[dest_reg_field] = m.s;
    notes.push_back(m);
  endtask

  // pause, offer a refused instruction meanwhile, leave on restart
  task pz(input logic [7:0] w);
    wait_cycles = w;
    pause_number = 18'($urandom % 32'h3FFFF) + 18'h00001;
    go(bit_plane_pkg::OP_PAUSE);
    @(negedge clk_sys);
    chk("paused", 64'h1, paused_reg);
    chk("pause code", pause_number, pause_code_reg);
    opcode = bit_plane_pkg::OP_CLEAR_RESULT_PLANE;
    for (int t = 0; t < 40 && restart !== 1'b1; t++)
      @(negedge clk_sys);
    chk("restart seen", 64'h1, restart);
    if (restart !== 1'b1)
      wrap_up;
    instr_valid = 1'b0;
    @(negedge clk_sys);
    chk("resumed", 64'h0, paused_reg);
  endtask

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    wrap_up;
  end

  initial
  begin
    void'($urandom(32'hcacf8d60));
    foreach (regs[j])
      regs[j] = 32'h0;
    m = '{default: '0};
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    for (int k = 0; k < 27; k++)
      if (k != 6)
        go(bit_plane_pkg::opcode_t'(5'(k)));
    for (int k = 0; k < 400; k++)
    begin
      go(bit_plane_pkg::opcode_t'(5'(($urandom % 26 + 7) % 27)));
      if (k % 60 == 59)
      begin
        @(negedge clk_sys);
        instr_valid = 1'b0;
        error_clear = 1'b1;
        @(negedge clk_sys);
        error_clear = 1'b0;
        m.e = 1'b0;
      end
    end
    pz(8'h00);
    pz(8'h09);
    pause_number = 18'h00000;
    go(bit_plane_pkg::OP_PAUSE);
    go(bit_plane_pkg::OP_NOP);
    @(negedge clk_sys);
    instr_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("zero pause refused", 64'h0, paused_reg);
    chk("notes left", 64'h0, 64'(notes.size()));
    wrap_up;
  end
endmodule
